// file: src/lcr_params.svh
// register offsets, field positions, reset values and counts of
// the loop control block; included by the package and the testbench
`ifndef LCR_PARAMS_SVH
`define LCR_PARAMS_SVH

// byte offsets on the register bus
`define LCR_OFF_LOOP_CTRL   8'h00
`define LCR_OFF_STATUS      8'h04
`define LCR_OFF_IRQ_STAT    8'h08
`define LCR_OFF_IRQ_MASK    8'h0c
`define LCR_OFF_MODE_CTRL   8'h10

// loop_control fields
`define LCR_B_MON_EN        7
`define LCR_B_PWR_ON        6
`define LCR_B_AUTO_BW       5
`define LCR_B_WIDE_SEL      4
`define LCR_B_RSVD          3
`define LCR_B_TICK_PS       2
`define LCR_B_WDOG_PS       1
`define LCR_B_FALLBACK      0
`define LCR_LOOP_RESET      8'hf1

// mode_control fields
`define LCR_B_OFF_IN_WAIT   0
`define LCR_B_CLK_SEL       1
`define LCR_B_PSTOP_SEL     2
`define LCR_MODE_RESET      8'h00

// status fields
`define LCR_B_ST_SELF       0
`define LCR_B_ST_MON        1
`define LCR_B_ST_WIDE       2
`define LCR_B_ST_PWR        3
`define LCR_B_ST_NEAR       4
`define LCR_B_ST_ONCE       5

// interrupt event positions
`define LCR_EV_SELF         0
`define LCR_EV_MONRST       1
`define LCR_EV_NEAR         2
`define LCR_NUM_EV          3
`define LCR_IRQ_MASK_RESET  3'h0

// synchronised pin inputs
`define LCR_NUM_SYNC        5

`endif

// file: src/lcr_pkg.sv
// types shared by the loop control block
// assumes the params header sits beside it in src/
`include "lcr_params.svh"

package lcr_pkg;

   // clock supervision state
   typedef enum logic [1:0] {
      LCR_CLK_NORMAL = 2'b00,
      LCR_CLK_SELF   = 2'b01,
      LCR_CLK_RESET  = 2'b10
   } lcr_clk_state_t;

   typedef logic [7:0] lcr_byte_t;
   typedef logic [`LCR_NUM_EV-1:0] lcr_ev_t;

endpackage

// file: src/lcr_sync.sv
// two-flop synchroniser for a group of level inputs
// assumes each input is a slow level from outside the clk_i domain
`timescale 1ns/10ps

module lcr_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta;

   // one pair of flops per bit; meta feeds only the second stage
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta[g]   <= 1'b0;
               sync_o[g] <= 1'b0;
            end else begin
               meta[g]   <= async_i[g];
               sync_o[g] <= meta[g];
            end
         end
      end
   endgenerate

endmodule

// file: src/lcr_irq.sv
// sticky event flags with write-one-to-clear, mask and level interrupt
// assumes events and clear strobes come from logic on clk_i
`timescale 1ns/10ps

module lcr_irq
   import lcr_pkg::*;
(
   // clock and reset
   input  wire logic    clk_i,
   input  wire logic    rst_i,
   // one-cycle event pulses
   input  wire lcr_ev_t event_i,
   // clear strobe per bit and mask register image
   input  wire lcr_ev_t clear_i,
   input  wire lcr_ev_t mask_i,
   // flags and interrupt
   output lcr_ev_t      flag_o,
   output logic         irq_o
);

   // per bit: set wins over a clear in the same cycle
   genvar g;
   generate
      for (g = 0; g < `LCR_NUM_EV; g++) begin : g_flag
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               flag_o[g] <= 1'b0;
            end else if (event_i[g]) begin
               flag_o[g] <= 1'b1;
            end else if (clear_i[g]) begin
               flag_o[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // registered level interrupt from unmasked flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(flag_o & mask_i);
      end
   end

endmodule

// file: src/lcr_top.sv
// loop control register of a clock and reset generator, wishbone slave
// assumes a classic wishbone master on clk_i and a separate oscillator
// monitor, mode logic and loop whose levels arrive asynchronously
//
// Summary of operation
// RULE_01: clock monitor enable write is dropped while self-clock mode runs.
// RULE_02: monitor enabled: clock failure starts monitor reset or self-clock.
// RULE_03: full stop without pseudo-stop disables the monitor entirely.
// RULE_04: power bit switches loop; writes dropped while loop clock selected.
// RULE_05: self-clock mode forces loop power; bit still reads its latch.
// RULE_06: powered loop with automatic bandwidth locks without software.
// RULE_07: loop-off-in-wait forces automatic bandwidth to one, writes dropped.
// RULE_08: automatic mode picks wide or narrow by nearness to target.
// RULE_09: automatic bandwidth off: only wide-filter select chooses bandwidth.
// RULE_10: wide-filter select always writable; one wide, zero narrow.
// RULE_11: tick-in-pseudo-stop bit keeps periodic tick running in pseudo-stop.
// RULE_12: tick stopped in pseudo-stop freezes dividers, no reinitialise.
// RULE_13: watchdog-in-pseudo-stop bit keeps watchdog running in pseudo-stop.
// RULE_14: watchdog stopped in pseudo-stop freezes dividers, no reinitialise.
// RULE_15: fallback enable takes first write in normal modes, any in special.
// RULE_16: clearing fallback enable is dropped while self-clock mode runs.
// RULE_17: fallback disabled: crystal failure gives clock monitor reset.
// RULE_18: fallback enabled: crystal failure enters self-clock mode.
// RULE_19: bit three is reserved, reads zero, ignores writes.
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/10ps

module lcr_top
   import lcr_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // asynchronous levels from the surrounding chip
   input  wire logic        osc_fail_i,
   input  wire logic        near_target_i,
   input  wire logic        stop_mode_i,
   input  wire logic        wait_mode_i,
   input  wire logic        special_mode_i,
   // loop controls
   output logic             loop_power_o,
   output logic             wide_bw_o,
   output logic             loop_clock_select_o,
   // clock supervision
   output logic             monitor_active_o,
   output logic             monitor_reset_o,
   output logic             self_clock_active_o,
   // periodic tick and watchdog run enables
   output logic             tick_run_o,
   output logic             watchdog_run_o,
   // interrupt
   output logic             irq_o
);

   // synchronised input levels
   logic           osc_fail;
   logic           near_target;
   logic           stop_mode;
   logic           wait_mode;
   logic           special_mode;

   // register state
   logic           clock_monitor_enable;
   logic           loop_power_on;
   logic           auto_bw;
   logic           wide_filter_select;
   logic           tick_in_pseudo_stop;
   logic           watchdog_in_pseudo_stop;
   logic           self_clock_fallback_enable;
   logic           fallback_written;
   logic           loop_off_in_wait;
   logic           loop_clock_select;
   logic           pseudo_stop_select;
   lcr_ev_t        irq_mask;
   lcr_ev_t        irq_flag;
   lcr_ev_t        irq_event;
   lcr_ev_t        irq_clear;
   logic           near_q;

   // bus decode
   logic           bus_req;
   logic           wr_now;
   lcr_byte_t      wbyte;
   lcr_byte_t      loop_image;
   lcr_byte_t      status_image;
   lcr_byte_t      mode_image;
   lcr_byte_t      next_rdata;

   // supervision state
   lcr_clk_state_t clk_state;
   lcr_clk_state_t next_clk_state;
   logic           self_clock;
   logic           pseudo_stop;
   logic           full_stop;
   logic           mon_active;

   // true when the word address hits a given byte offset
   function automatic logic reg_hit(input logic [7:0] adr,
                                    input logic [7:0] off);
      reg_hit = (adr[7:2] == off[7:2]);
   endfunction

   // pin levels cross into clk_i through two flops
   lcr_sync #(
      .W (`LCR_NUM_SYNC)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({osc_fail_i, near_target_i, stop_mode_i, wait_mode_i,
                 special_mode_i}),
      .sync_o  ({osc_fail, near_target, stop_mode, wait_mode,
                 special_mode})
   );

   // stop flavours and monitor gating
   assign self_clock  = (clk_state == LCR_CLK_SELF);
   assign pseudo_stop = stop_mode & pseudo_stop_select;
   assign full_stop   = stop_mode & ~pseudo_stop_select;
   assign mon_active  = clock_monitor_enable & ~full_stop;  // see RULE_03

   // ack one cycle after the request, dropped the cycle after
   assign bus_req = cyc_i & stb_i;
   assign wr_now  = bus_req & we_i & ack_o & sel_i[0];
   assign wbyte   = dat_i[7:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_req & ~ack_o;
      end
   end

   // register images as read back; loop control bit three always zero
   always_comb begin
      loop_image = 8'h00;                                    // see RULE_19
      loop_image[`LCR_B_MON_EN]   = clock_monitor_enable;
      loop_image[`LCR_B_PWR_ON]   = loop_power_on;          // see RULE_05
      loop_image[`LCR_B_AUTO_BW]  = auto_bw;
      loop_image[`LCR_B_WIDE_SEL] = wide_filter_select;
      loop_image[`LCR_B_TICK_PS]  = tick_in_pseudo_stop;
      loop_image[`LCR_B_WDOG_PS]  = watchdog_in_pseudo_stop;
      loop_image[`LCR_B_FALLBACK] = self_clock_fallback_enable;
   end

   always_comb begin
      status_image = 8'h00;
      status_image[`LCR_B_ST_SELF] = self_clock;
      status_image[`LCR_B_ST_MON]  = mon_active;
      status_image[`LCR_B_ST_WIDE] = wide_bw_o;
      status_image[`LCR_B_ST_PWR]  = loop_power_o;
      status_image[`LCR_B_ST_NEAR] = near_target;
      status_image[`LCR_B_ST_ONCE] = fallback_written;
   end

   always_comb begin
      mode_image = 8'h00;
      mode_image[`LCR_B_OFF_IN_WAIT] = loop_off_in_wait;
      mode_image[`LCR_B_CLK_SEL]     = loop_clock_select;
      mode_image[`LCR_B_PSTOP_SEL]   = pseudo_stop_select;
   end

   // read multiplexer; unmapped offsets read zero
   always_comb begin
      next_rdata = 8'h00;
      if (reg_hit(adr_i, `LCR_OFF_LOOP_CTRL)) begin
         next_rdata = loop_image;
      end else if (reg_hit(adr_i, `LCR_OFF_STATUS)) begin
         next_rdata = status_image;
      end else if (reg_hit(adr_i, `LCR_OFF_IRQ_STAT)) begin
         next_rdata = {5'h00, irq_flag};
      end else if (reg_hit(adr_i, `LCR_OFF_IRQ_MASK)) begin
         next_rdata = {5'h00, irq_mask};
      end else if (reg_hit(adr_i, `LCR_OFF_MODE_CTRL)) begin
         next_rdata = mode_image;
      end
   end

   // read data captured with the ack, zero otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (bus_req & ~ack_o & ~we_i) begin
         dat_o <= {24'h000000, next_rdata};
      end else begin
         dat_o <= 32'h00000000;
      end
   end

   // clock monitor enable, locked while self-clock mode runs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_monitor_enable <= 1'(`LCR_LOOP_RESET >> `LCR_B_MON_EN);
      end else if (wr_now & reg_hit(adr_i, `LCR_OFF_LOOP_CTRL) &
                   ~self_clock) begin                        // see RULE_01
         clock_monitor_enable <= wbyte[`LCR_B_MON_EN];
      end
   end

   // loop power latch, locked while the loop clock drives the system
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_power_on <= 1'(`LCR_LOOP_RESET >> `LCR_B_PWR_ON);
      end else if (wr_now & reg_hit(adr_i, `LCR_OFF_LOOP_CTRL) &
                   ~loop_clock_select) begin                 // see RULE_04
         loop_power_on <= wbyte[`LCR_B_PWR_ON];
      end
   end

   // automatic bandwidth, held at one while loop-off-in-wait is set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         auto_bw <= 1'(`LCR_LOOP_RESET >> `LCR_B_AUTO_BW);
      end else if (loop_off_in_wait) begin
         auto_bw <= 1'b1;                                    // see RULE_07
      end else if (wr_now & reg_hit(adr_i, `LCR_OFF_LOOP_CTRL)) begin
         auto_bw <= wbyte[`LCR_B_AUTO_BW];
      end
   end

   // freely writable loop bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wide_filter_select      <= 1'(`LCR_LOOP_RESET >> `LCR_B_WIDE_SEL);
         tick_in_pseudo_stop     <= 1'(`LCR_LOOP_RESET >> `LCR_B_TICK_PS);
         watchdog_in_pseudo_stop <= 1'(`LCR_LOOP_RESET >> `LCR_B_WDOG_PS);
      end else if (wr_now & reg_hit(adr_i, `LCR_OFF_LOOP_CTRL)) begin
         wide_filter_select      <= wbyte[`LCR_B_WIDE_SEL];  // see RULE_10
         tick_in_pseudo_stop     <= wbyte[`LCR_B_TICK_PS];   // see RULE_11
         watchdog_in_pseudo_stop <= wbyte[`LCR_B_WDOG_PS];   // see RULE_13
      end
   end

   // fallback enable: write once in normal modes, never cleared in
   // self-clock mode; any write attempt uses up the single chance
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         self_clock_fallback_enable <= 1'(`LCR_LOOP_RESET >> `LCR_B_FALLBACK);
         fallback_written           <= 1'b0;
      end else if (wr_now & reg_hit(adr_i, `LCR_OFF_LOOP_CTRL)) begin
         fallback_written <= 1'b1;
         if ((special_mode | ~fallback_written) &            // see RULE_15
             ~(self_clock & ~wbyte[`LCR_B_FALLBACK])) begin  // see RULE_16
            self_clock_fallback_enable <= wbyte[`LCR_B_FALLBACK];
         end
      end
   end

   // mode bits; loop clock select is held low whenever the next state is self-clock, in stop
   // and in wait with loop-off-in-wait set, over a write in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_off_in_wait   <= 1'(`LCR_MODE_RESET >> `LCR_B_OFF_IN_WAIT);
         loop_clock_select  <= 1'(`LCR_MODE_RESET >> `LCR_B_CLK_SEL);
         pseudo_stop_select <= 1'(`LCR_MODE_RESET >> `LCR_B_PSTOP_SEL);
      end else begin
         if (wr_now & reg_hit(adr_i, `LCR_OFF_MODE_CTRL)) begin
            loop_off_in_wait   <= wbyte[`LCR_B_OFF_IN_WAIT];
            loop_clock_select  <= wbyte[`LCR_B_CLK_SEL];
            pseudo_stop_select <= wbyte[`LCR_B_PSTOP_SEL];
         end
         if ((next_clk_state == LCR_CLK_SELF) | stop_mode |
             (wait_mode & loop_off_in_wait)) begin
            loop_clock_select <= 1'b0;
         end
      end
   end

   // interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= `LCR_IRQ_MASK_RESET;
      end else if (wr_now & reg_hit(adr_i, `LCR_OFF_IRQ_MASK)) begin
         irq_mask <= wbyte[`LCR_NUM_EV-1:0];
      end
   end

   // clock supervision: failure seen by an active monitor goes to
   // self-clock or to monitor reset; both end when the clock returns
   always_comb begin
      next_clk_state = clk_state;
      unique case (clk_state)
         LCR_CLK_NORMAL: begin
            if (osc_fail & mon_active) begin                 // see RULE_02
               if (self_clock_fallback_enable) begin
                  next_clk_state = LCR_CLK_SELF;             // see RULE_18
               end else begin
                  next_clk_state = LCR_CLK_RESET;            // see RULE_17
               end
            end
         end
         LCR_CLK_SELF: begin
            if (~osc_fail) begin
               next_clk_state = LCR_CLK_NORMAL;
            end
         end
         LCR_CLK_RESET: begin
            if (~osc_fail) begin
               next_clk_state = LCR_CLK_NORMAL;
            end
         end
         default: begin
            next_clk_state = LCR_CLK_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_state <= LCR_CLK_NORMAL;
      end else begin
         clk_state <= next_clk_state;
      end
   end

   // events: self-clock entry, monitor reset entry, lock range reached
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         near_q <= 1'b0;
      end else begin
         near_q <= near_target;
      end
   end

   always_comb begin
      irq_event = '0;
      irq_event[`LCR_EV_SELF]   = (clk_state != LCR_CLK_SELF) &
                                  (next_clk_state == LCR_CLK_SELF);
      irq_event[`LCR_EV_MONRST] = (clk_state != LCR_CLK_RESET) &
                                  (next_clk_state == LCR_CLK_RESET);
      irq_event[`LCR_EV_NEAR]   = near_target & ~near_q;
   end

   assign irq_clear = (wr_now & reg_hit(adr_i, `LCR_OFF_IRQ_STAT)) ?
                      wbyte[`LCR_NUM_EV-1:0] : '0;

   lcr_irq u_irq (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .event_i (irq_event),
      .clear_i (irq_clear),
      .mask_i  (irq_mask),
      .flag_o  (irq_flag),
      .irq_o   (irq_o)
   );

   // loop drive: self-clock forces power, wait with loop-off powers down;
   // auto mode widens the filter until near target, then tracks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_power_o        <= 1'b0;
         wide_bw_o           <= 1'b0;
         loop_clock_select_o <= 1'b0;
      end else begin
         loop_power_o <= self_clock |                        // see RULE_05
                         (loop_power_on &                    // see RULE_04
                          ~(wait_mode & loop_off_in_wait));
         if (auto_bw) begin
            wide_bw_o <= ~near_target;            // see RULE_06, see RULE_08
         end else begin
            wide_bw_o <= wide_filter_select;                 // see RULE_09
         end
         loop_clock_select_o <= loop_clock_select;
      end
   end

   // supervision outputs and pseudo-stop run enables; a low run enable
   // only freezes the dividers, no reinitialise is ever requested
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         monitor_active_o    <= 1'b0;
         monitor_reset_o     <= 1'b0;
         self_clock_active_o <= 1'b0;
         tick_run_o          <= 1'b0;
         watchdog_run_o      <= 1'b0;
      end else begin
         monitor_active_o    <= mon_active;                  // see RULE_03
         monitor_reset_o     <= (clk_state == LCR_CLK_RESET); // see RULE_17
         self_clock_active_o <= self_clock;                  // see RULE_18
         tick_run_o     <= ~pseudo_stop | tick_in_pseudo_stop;
         // see RULE_11, see RULE_12
         watchdog_run_o <= ~pseudo_stop | watchdog_in_pseudo_stop;
         // see RULE_13, see RULE_14
      end
   end

endmodule

// file: sim/lcr_assertions.sv
// concurrent checks on the ports of the loop control block
// assumes one clock domain, bound into every lcr_top instance
`timescale 1ns/10ps

module lcr_checker (
   // clock, reset and bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        stop_mode_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // loop and supervision outputs
   input wire logic        loop_power_o,
   input wire logic        loop_clock_select_o,
   input wire logic        monitor_active_o,
   input wire logic        monitor_reset_o,
   input wire logic        self_clock_active_o,
   input wire logic        tick_run_o,
   input wire logic        watchdog_run_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // a request seen, steady self-clock, steady run mode
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_self;
      self_clock_active_o [*3];
   endsequence
   sequence s_run;
      !stop_mode_i [*5];
   endsequence

   ack_timing_a: assert property (s_req |=> ack_o)
      else $error("no ack one cycle after request");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   dat_quiet_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack cycle");
   fail_excl_a: assert property (!(monitor_reset_o && self_clock_active_o))
      else $error("monitor reset and self-clock together");
   self_cause_a: assert property ($rose(self_clock_active_o) |->
      $past(monitor_active_o) || $past(monitor_active_o, 2))
      else $error("self-clock entered with monitor inactive");
   self_power_a: assert property (s_self |-> loop_power_o)
      else $error("loop not powered in self-clock");
   self_clksel_a: assert property (s_self |-> !loop_clock_select_o)
      else $error("loop clock selected in self-clock");
   tick_run_a: assert property (s_run |-> tick_run_o)
      else $error("tick frozen outside stop");
   wdog_run_a: assert property (s_run |-> watchdog_run_o)
      else $error("watchdog frozen outside stop");
endmodule

bind lcr_top lcr_checker i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .stop_mode_i(stop_mode_i), .dat_o(dat_o), .ack_o(ack_o),
   .loop_power_o(loop_power_o), .loop_clock_select_o(loop_clock_select_o),
   .monitor_active_o(monitor_active_o), .monitor_reset_o(monitor_reset_o),
   .self_clock_active_o(self_clock_active_o), .tick_run_o(tick_run_o),
   .watchdog_run_o(watchdog_run_o));

// file: sim/tb.sv
// self-checking bench for the loop control block
// assumes the package, params header and design files are compiled first
`timescale 1ns/10ps
`include "lcr_params.svh"

module tb;
   import lcr_pkg::*;
   localparam logic [7:0] a_loop = `LCR_OFF_LOOP_CTRL;
   localparam logic [7:0] a_mode = `LCR_OFF_MODE_CTRL;
   localparam logic [7:0] a_stat = `LCR_OFF_IRQ_STAT;
   localparam logic [7:0] a_mask = `LCR_OFF_IRQ_MASK;
   // design inputs
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic        osc_fail_i = 1'b0, near_target_i = 1'b0;
   logic        stop_mode_i = 1'b0, wait_mode_i = 1'b0;
   logic        special_mode_i = 1'b0;
   // design outputs
   logic [31:0] dat_o;
   logic        ack_o, loop_power_o, wide_bw_o, loop_clock_select_o;
   logic        monitor_active_o, monitor_reset_o, self_clock_active_o;
   logic        tick_run_o, watchdog_run_o, irq_o;
   int          num_errors = 0;
   int          total_checks = 0;

   // 25 MHz clock
   always #20 clk_i = ~clk_i;

   lcr_top i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .osc_fail_i(osc_fail_i),
      .near_target_i(near_target_i), .stop_mode_i(stop_mode_i),
      .wait_mode_i(wait_mode_i), .special_mode_i(special_mode_i),
      .loop_power_o(loop_power_o), .wide_bw_o(wide_bw_o),
      .loop_clock_select_o(loop_clock_select_o),
      .monitor_active_o(monitor_active_o),
      .monitor_reset_o(monitor_reset_o),
      .self_clock_active_o(self_clock_active_o), .tick_run_o(tick_run_o),
      .watchdog_run_o(watchdog_run_o), .irq_o(irq_o));

   // counts and verdict, then stop
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // compare one value
   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
                     input lcr_byte_t d, output lcr_byte_t q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o[7:0];
      if (ack_o !== 1'b1) begin
         num_errors++;
         results();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input lcr_byte_t d);
      lcr_byte_t q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
                      input lcr_byte_t e);
      lcr_byte_t q;
      wb(1'b0, a, 8'h00, q);
      check(nm, {24'h0, e}, {24'h0, q});
   endtask

   // pin to output takes up to four edges
   task automatic settle();
      repeat (5) @(posedge clk_i);
   endtask

   // reset values, reserved bit, single fallback write
   task automatic t_regs();
      rdc("loop reset", a_loop, `LCR_LOOP_RESET);
      rdc("mode reset", a_mode, `LCR_MODE_RESET);
      rdc("unmapped", 8'h20, 8'h00);
      wr(a_loop, 8'hfe);
      rdc("first write", a_loop, 8'hf6);
      wr(a_loop, 8'h01);
      rdc("second write", a_loop, 8'h00);
      settle();
      check("power off", 32'h0, {31'h0, loop_power_o});
      $display("test regs finished");
   endtask

   // bandwidth selection and the near-target interrupt
   task automatic t_bw();
      near_target_i <= 1'b1;
      wr(a_mode, 8'h01);
      wr(a_loop, 8'h10);
      rdc("auto forced", a_loop, 8'h30);
      settle();
      check("auto near", 32'h0, {31'h0, wide_bw_o});
      check("irq masked", 32'h0, {31'h0, irq_o});
      wr(a_mask, 8'h04);
      near_target_i <= 1'b0;
      settle();
      check("auto far", 32'h1, {31'h0, wide_bw_o});
      check("irq raised", 32'h1, {31'h0, irq_o});
      wr(a_stat, 8'h04);
      settle();
      check("irq cleared", 32'h0, {31'h0, irq_o});
      near_target_i <= 1'b1;
      wr(a_mode, 8'h00);
      wr(a_loop, 8'h10);
      settle();
      check("manual wide", 32'h1, {31'h0, wide_bw_o});
      near_target_i <= 1'b0;
      wr(a_loop, 8'h00);
      settle();
      check("manual narrow", 32'h0, {31'h0, wide_bw_o});
      $display("test bandwidth finished");
   endtask

   // power bit and its lock under loop clock select
   task automatic t_power();
      wr(a_loop, 8'h40);
      settle();
      check("power on", 32'h1, {31'h0, loop_power_o});
      wr(a_mode, 8'h02);
      wr(a_loop, 8'h00);
      rdc("power locked", a_loop, 8'h40);
      settle();
      check("clock select", 32'h1, {31'h0, loop_clock_select_o});
      wr(a_mode, 8'h00);
      wr(a_loop, 8'h00);
      settle();
      check("power off", 32'h0, {31'h0, loop_power_o});
      $display("test power finished");
   endtask

   // self-clock fallback and monitor reset in special mode
   task automatic t_self();
      special_mode_i <= 1'b1;
      settle();
      wr(a_loop, 8'h81);
      wr(a_mask, 8'h01);
      osc_fail_i <= 1'b1;
      settle();
      check("self on", 32'h1, {31'h0, self_clock_active_o});
      check("power forced", 32'h1, {31'h0, loop_power_o});
      check("self irq", 32'h1, {31'h0, irq_o});
      wr(a_loop, 8'h00);
      rdc("self locks", a_loop, 8'h81);
      osc_fail_i <= 1'b0;
      settle();
      check("self off", 32'h0, {31'h0, self_clock_active_o});
      wr(a_loop, 8'h80);
      rdc("special rewrite", a_loop, 8'h80);
      osc_fail_i <= 1'b1;
      settle();
      check("mon reset", 32'h1, {31'h0, monitor_reset_o});
      check("no self", 32'h0, {31'h0, self_clock_active_o});
      osc_fail_i <= 1'b0;
      wr(a_stat, 8'h01);
      settle();
      check("self irq cleared", 32'h0, {31'h0, irq_o});
      $display("test self-clock finished");
   endtask

   // full stop and pseudo-stop
   task automatic t_stop();
      stop_mode_i <= 1'b1;
      settle();
      check("mon stop", 32'h0, {31'h0, monitor_active_o});
      osc_fail_i <= 1'b1;
      settle();
      check("no reset", 32'h0, {31'h0, monitor_reset_o});
      osc_fail_i <= 1'b0;
      settle();
      wr(a_mode, 8'h04);
      settle();
      check("mon pseudo", 32'h1, {31'h0, monitor_active_o});
      check("tick frozen", 32'h0, {31'h0, tick_run_o});
      check("wdog frozen", 32'h0, {31'h0, watchdog_run_o});
      wr(a_loop, 8'h86);
      settle();
      check("tick runs", 32'h1, {31'h0, tick_run_o});
      check("wdog runs", 32'h1, {31'h0, watchdog_run_o});
      stop_mode_i <= 1'b0;
      $display("test stop finished");
   endtask

   // reset, scenarios, verdict
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_bw();
      t_power();
      t_self();
      t_stop();
      results();
   end
endmodule
